// [logic/ampi_diag_regs.sv]
/*
 * Control and diagnostic byte bank of a four-channel amplifier behind an
 * I2C target port. The bus side runs on link_clk, the diagnostic side on clk.
 * Assumes scl/sda are open-drain with external pull-ups and that fault,
 * thermal and current comparator inputs are asynchronous levels.
 * A diagnostic cycle runs once per enable or read and then holds.
 */
`timescale 1ns/1ns
`include "ampi_params.svh"

module ampi_diag_regs #(
    parameter int unsigned DIAG_CYCLES = `AMPI_DIAG_CYC
) (
    input  wire logic       clk,          // Core clock, 125 MHz
    input  wire logic       rst,          // Async reset, active high
    input  wire logic       clk_en,       // Freezes core state when low
    input  wire logic       link_clk,     // Bus side clock
    input  wire logic       scl_in,       // Bus clock level
    input  wire logic       sda_in,       // Bus data level
    output logic            sda_out,      // Bus data drive value
    output logic            sda_oe,       // High while pulling data low
    input  wire logic [3:0] short_load,   // Per-channel short across load
    input  wire logic [3:0] open_load,    // Per-channel open load
    input  wire logic [3:0] out_offset,   // Per-channel output offset
    input  wire logic [3:0] short_vcc,    // Per-channel short to supply
    input  wire logic [3:0] short_gnd,    // Per-channel short to ground
    input  wire logic [3:0] cur_lt_125,   // Peak current below 125 mA
    input  wire logic [3:0] cur_lt_250,   // Peak current below 250 mA
    input  wire logic [3:0] cur_gt_250,   // Peak current above 250 mA
    input  wire logic [3:0] cur_gt_500,   // Peak current above 500 mA
    input  wire logic [2:0] thermal_warn, // Warnings one, two, three
    output logic [7:0]      primary_control_byte,   // Stored primary byte
    output logic [7:0]      secondary_control_byte, // Stored secondary byte
    output logic            unmute_front, // Front pair playing
    output logic            unmute_rear,  // Rear pair playing
    output logic            diag_done     // Diagnostic cycle terminated
);

    // ****************************************************************
    // Bus side, link clock domain
    // ****************************************************************
    ampi_pkg::ampi_link_t l_q;
    ampi_pkg::ampi_link_t l_d;
    ampi_pkg::ampi_core_t c_q;
    ampi_pkg::ampi_core_t c_d;

    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;

    assign scl_rise  = l_q.scl_s[1] & ~l_q.scl_s[2];
    assign scl_fall  = ~l_q.scl_s[1] & l_q.scl_s[2];
    assign bus_start = l_q.scl_s[1] & l_q.scl_s[2] & ~l_q.sda_s[1] & l_q.sda_s[2];
    assign bus_stop  = l_q.scl_s[1] & l_q.scl_s[2] & l_q.sda_s[1] & ~l_q.sda_s[2];

    always_comb begin
        l_d = l_q;
        l_d.scl_s = {l_q.scl_s[1:0], scl_in};
        l_d.sda_s = {l_q.sda_s[1:0], sda_in};
        l_d.pub_s = {l_q.pub_s[1:0], c_q.pub_tgl};
        // Core word is held stable until this capture is acknowledged
        if (l_q.pub_s[2] != l_q.pub_s[1]) begin
            l_d.pub = c_q.pub;
            l_d.ack = l_q.pub_s[1];
        end
        if (bus_start) begin
            l_d.st  = ampi_pkg::ST_ADDR;
            l_d.cnt = 4'h0;
            l_d.idx = 3'h0;
            l_d.rw  = 1'b0;
            l_d.oe  = 1'b0;
        end else if (bus_stop) begin
            if (!l_q.rw && l_q.idx == `AMPI_WR_BYTES) begin
                l_d.ctl     = {l_q.wb0, l_q.wb1};
                l_d.ctl_tgl = ~l_q.ctl_tgl;
            end
            l_d.st = ampi_pkg::ST_IDLE;
            l_d.oe = 1'b0;
        end else begin
            case (l_q.st)
                ampi_pkg::ST_ADDR,
                ampi_pkg::ST_WBYTE: begin
                    if (scl_rise) begin
                        l_d.sr  = {l_q.sr[6:0], l_q.sda_s[1]};
                        l_d.cnt = l_q.cnt + 4'h1;
                    end else if (scl_fall && l_q.cnt == `AMPI_BIT_CNT) begin
                        if (l_q.st == ampi_pkg::ST_ADDR) begin
                            if (l_q.sr[7:1] == `AMPI_I2C_ADDR) begin
                                l_d.rw = l_q.sr[0];
                                l_d.oe = 1'b1;
                                l_d.st = ampi_pkg::ST_AACK;
                                if (l_q.sr[0]) begin
                                    l_d.rd_tgl = ~l_q.rd_tgl;
                                    l_d.snap   = l_q.pub;
                                    l_d.tx     = l_q.pub[31:24];
                                end
                            end else begin
                                l_d.st = ampi_pkg::ST_IDLE;
                            end
                        end else begin
                            // a third byte is not acknowledged
                            if (l_q.idx < `AMPI_WR_BYTES) begin
                                l_d.oe  = 1'b1;
                                l_d.idx = l_q.idx + 3'h1;
                                if (l_q.idx == 3'h0) begin
                                    l_d.wb0 = l_q.sr;
                                end else begin
                                    l_d.wb1 = l_q.sr;
                                end
                            end
                            l_d.st = ampi_pkg::ST_WACK;
                        end
                    end
                end
                ampi_pkg::ST_AACK: begin
                    if (scl_fall) begin
                        l_d.cnt = 4'h0;
                        if (l_q.rw) begin
                            l_d.oe = ~l_q.tx[7];
                            l_d.st = ampi_pkg::ST_RBYTE;
                        end else begin
                            l_d.oe = 1'b0;
                            l_d.st = ampi_pkg::ST_WBYTE;
                        end
                    end
                end
                ampi_pkg::ST_WACK: begin
                    if (scl_fall) begin
                        l_d.oe  = 1'b0;
                        l_d.cnt = 4'h0;
                        l_d.st  = ampi_pkg::ST_WBYTE;
                    end
                end
                ampi_pkg::ST_RBYTE: begin
                    if (scl_rise) begin
                        l_d.cnt = l_q.cnt + 4'h1;
                    end else if (scl_fall) begin
                        if (l_q.cnt == `AMPI_BIT_CNT) begin
                            l_d.oe = 1'b0;
                            l_d.st = ampi_pkg::ST_RACK;
                        end else begin
                            l_d.tx = {l_q.tx[6:0], 1'b1};
                            l_d.oe = ~l_q.tx[6];
                        end
                    end
                end
                ampi_pkg::ST_RACK: begin
                    if (scl_rise) begin
                        l_d.nack = l_q.sda_s[1];
                    end else if (scl_fall) begin
                        if (l_q.nack) begin
                            l_d.st = ampi_pkg::ST_IDLE;
                        end else begin
                            // channel two to four, then ones
                            l_d.idx = l_q.idx + 3'h1;
                            case (l_q.idx)
                                3'h0:    l_d.tx = l_q.snap[23:16];
                                3'h1:    l_d.tx = l_q.snap[15:8];
                                3'h2:    l_d.tx = l_q.snap[7:0];
                                default: l_d.tx = 8'hFF;
                            endcase
                            if (l_q.idx >= `AMPI_RD_LAST) begin
                                l_d.idx = `AMPI_RD_LAST;
                            end
                            l_d.oe  = 1'b0;
                            l_d.cnt = 4'h0;
                            l_d.st  = ampi_pkg::ST_RBYTE;
                            case (l_q.idx)
                                3'h0:    l_d.oe = ~l_q.snap[23];
                                3'h1:    l_d.oe = ~l_q.snap[15];
                                3'h2:    l_d.oe = ~l_q.snap[7];
                                default: l_d.oe = 1'b0;
                            endcase
                        end
                    end
                end
                default: begin
                    l_d.st = ampi_pkg::ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge link_clk or posedge rst) begin
        if (rst) begin
            l_q       <= '0;
            l_q.scl_s <= 3'h7;
            l_q.sda_s <= 3'h7;
            l_q.st    <= ampi_pkg::ST_IDLE;
        end else begin
            l_q <= l_d;
        end
    end

    // Open drain: only ever pulls low
    assign sda_out = 1'b0;
    assign sda_oe  = l_q.oe;

    // ****************************************************************
    // Diagnostic side, core clock domain
    // ****************************************************************
    logic [38:0] raw_in;
    logic [3:0]  s_sload;
    logic [3:0]  s_open;
    logic [3:0]  s_offs;
    logic [3:0]  s_svcc;
    logic [3:0]  s_sgnd;
    logic [3:0]  s_lt125;
    logic [3:0]  s_lt250;
    logic [3:0]  s_gt250;
    logic [3:0]  s_gt500;
    logic [2:0]  s_tw;
    logic [3:0]  cur_nx;
    logic [23:0] live;
    logic [31:0] diag_word;
    logic        ctl_evt;
    logic        rd_evt;

    assign raw_in = {thermal_warn, short_gnd, short_vcc, out_offset, open_load,
                     short_load, cur_lt_125, cur_lt_250, cur_gt_250, cur_gt_500};
    assign s_tw    = c_q.raw_s2[38:36];
    assign s_sgnd  = c_q.raw_s2[35:32];
    assign s_svcc  = c_q.raw_s2[31:28];
    assign s_offs  = c_q.raw_s2[27:24];
    assign s_open  = c_q.raw_s2[23:20];
    assign s_sload = c_q.raw_s2[19:16];
    assign s_lt125 = c_q.raw_s2[15:12];
    assign s_lt250 = c_q.raw_s2[11:8];
    assign s_gt250 = c_q.raw_s2[7:4];
    assign s_gt500 = c_q.raw_s2[3:0];
    assign ctl_evt = c_q.ct_s[2] ^ c_q.ct_s[1];
    assign rd_evt  = c_q.rd_s[2] ^ c_q.rd_s[1];

    for (genvar i = 0; i < 4; i++) begin : g_ch
        logic cur_set;
        logic cur_clr;
        // threshold pair picked by secondary bit 7
        assign cur_set = c_q.sec[`AMPI_S_CUR_LOW] ? s_lt125[i] : s_lt250[i];
        assign cur_clr = c_q.sec[`AMPI_S_CUR_LOW] ? s_gt250[i] : s_gt500[i];
        assign cur_nx[i] = !c_q.sec[`AMPI_S_CUR_EN] ? 1'b0 :
                           cur_set ? 1'b1 : cur_clr ? 1'b0 : c_q.cur[i];
        // flags of one channel; bit 2 by diag type
        assign live[23-6*i -: 6] = {c_q.cur[i], c_q.perm, s_sload[i],
                                    c_q.perm ? s_offs[i] : s_open[i],
                                    s_svcc[i], s_sgnd[i]};
    end

    assign diag_word[31:24] = {s_tw[0], c_q.term, c_q.res[23:18]};
    assign diag_word[23:16] = {c_q.prim[`AMPI_P_OFFS_EN] & c_q.prim[`AMPI_P_DIAG_EN],
                               c_q.ssr_mute, c_q.res[17:12]};
    assign diag_word[15:8]  = {c_q.sec[`AMPI_S_RUN], c_q.prim[`AMPI_P_DIAG_EN],
                               c_q.res[11:6]};
    assign diag_word[7:0]   = {s_tw[1], s_tw[2], c_q.res[5:0]};

    always_comb begin
        c_d = c_q;
        c_d.raw_s1 = raw_in;
        c_d.raw_s2 = c_q.raw_s1;
        c_d.ct_s   = {c_q.ct_s[1:0], l_q.ctl_tgl};
        c_d.rd_s   = {c_q.rd_s[1:0], l_q.rd_tgl};
        c_d.ak_s   = {c_q.ak_s[0], l_q.ack};
        c_d.cur    = cur_nx;
        if (ctl_evt) begin
            c_d.prim = l_q.ctl[15:8];
            c_d.sec  = l_q.ctl[7:0] & `AMPI_SEC_MASK;
        end
        if (c_q.pend && c_q.ak_s[1] == c_q.pub_tgl) begin
            c_d.pend = 1'b0;
        end else if (!c_q.pend && c_q.pub != diag_word) begin
            c_d.pub     = diag_word;
            c_d.pub_tgl = ~c_q.pub_tgl;
            c_d.pend    = 1'b1;
        end
        if (!c_q.prim[`AMPI_P_DIAG_EN]) begin
            c_d.tmr  = 16'h0000;
            c_d.term = 1'b0;
            c_d.acc  = 24'hFF_FFFF;
        end else if (rd_evt) begin
            // restart, results kept
            // A read re-arms exactly one cycle; the host sees the last
            // results now and the new ones only on its following read
            c_d.tmr  = 16'h0000;
            c_d.term = 1'b0;
            c_d.acc  = 24'hFF_FFFF;
        end else if (c_q.term) begin
            // Finished cycle waits for a read; a free-running cycle
            // would let a fault change show without the second read
            c_d.tmr = 16'h0000;
            c_d.acc = 24'hFF_FFFF;
        end else if (c_q.tmr == 16'(DIAG_CYCLES - 1)) begin
            // Only faults stable over the whole cycle are reported
            c_d.res  = c_q.acc & live;
            c_d.term = 1'b1;
            c_d.perm = c_q.sec[`AMPI_S_RUN];
            c_d.tmr  = 16'h0000;
            c_d.acc  = 24'hFF_FFFF;
        end else begin
            c_d.tmr = c_q.tmr + 16'h0001;
            c_d.acc = c_q.acc & live;
        end
        if (!c_q.sec[`AMPI_S_RUN]) begin
            c_d.perm = 1'b0;
        end
        if (!c_q.sec[`AMPI_S_SSR_EN] || !c_q.sec[`AMPI_S_RUN]) begin
            c_d.ssr_mute = 1'b0;
        end else if (c_q.prim[`AMPI_P_OFFS_EN] && |s_offs) begin
            c_d.ssr_mute = 1'b1;
        end
        c_d.unm_f = c_q.prim[`AMPI_P_UNMUTE_F] & ~c_q.ssr_mute;
        c_d.unm_r = c_q.prim[`AMPI_P_UNMUTE_R] & ~c_q.ssr_mute;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            c_q      <= '0;
            c_q.prim <= `AMPI_PRIM_RST;
            c_q.sec  <= `AMPI_SEC_RST;
            c_q.acc  <= 24'hFF_FFFF;
        end else if (clk_en) begin
            c_q <= c_d;
        end
    end

    // remaining fields go out as stored
    assign primary_control_byte   = c_q.prim;
    assign secondary_control_byte = c_q.sec;
    assign unmute_front           = c_q.unm_f;
    assign unmute_rear            = c_q.unm_r;
    assign diag_done              = c_q.term;

endmodule

// [logic/ampi_params.svh]
/*
 * Constants of the amplifier control and diagnostic byte interface:
 * bus address, byte counts, control bit positions, reset values, timing.
 * Assumes it is included by the ampi top module, the host model and the bench only.
 */
`ifndef AMPI_PARAMS_SVH
`define AMPI_PARAMS_SVH

// ****************************************************************
// Bus framing
// ****************************************************************
`define AMPI_I2C_ADDR   7'h6C
`define AMPI_WR_BYTES   3'h2
`define AMPI_RD_LAST    3'h3
`define AMPI_BIT_CNT    4'h8

// ****************************************************************
// Primary control byte fields
// ****************************************************************
`define AMPI_P_MUTE_THR 7
`define AMPI_P_DIAG_EN  6
`define AMPI_P_OFFS_EN  5
`define AMPI_P_GAIN_F   4
`define AMPI_P_GAIN_R   3
`define AMPI_P_UNMUTE_F 2
`define AMPI_P_UNMUTE_R 1
`define AMPI_P_CLIP_10  0

// ****************************************************************
// Secondary control byte fields
// ****************************************************************
`define AMPI_S_CUR_LOW  7
`define AMPI_S_FAST_MUT 5
`define AMPI_S_RUN      4
`define AMPI_S_LINE_DRV 3
`define AMPI_S_CUR_EN   2
`define AMPI_S_SSR_EN   0
`define AMPI_SEC_MASK   8'hBD

// ****************************************************************
// Reset values and timing
// ****************************************************************
`define AMPI_PRIM_RST   8'h00
`define AMPI_SEC_RST    8'h00
`define AMPI_CLK_MHZ    125
`define AMPI_DIAG_US    100
`define AMPI_DIAG_CYC   (`AMPI_DIAG_US * `AMPI_CLK_MHZ)

`endif

// [logic/ampi_pkg.sv]
/*
 * Types of the amplifier control and diagnostic byte interface.
 * Assumes the constants header supplies all numeric values.
 */
package ampi_pkg;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'h0,
        ST_ADDR  = 3'h1,
        ST_AACK  = 3'h2,
        ST_WBYTE = 3'h3,
        ST_WACK  = 3'h4,
        ST_RBYTE = 3'h5,
        ST_RACK  = 3'h6
    } ampi_lst_t;

    typedef struct packed {
        logic [2:0]  scl_s;
        logic [2:0]  sda_s;
        logic [2:0]  pub_s;
        ampi_lst_t   st;
        logic [7:0]  sr;
        logic [3:0]  cnt;
        logic [2:0]  idx;
        logic        rw;
        logic        nack;
        logic        oe;
        logic [7:0]  tx;
        logic [7:0]  wb0;
        logic [7:0]  wb1;
        logic [31:0] pub;
        logic [31:0] snap;
        logic [15:0] ctl;
        logic        ctl_tgl;
        logic        rd_tgl;
        logic        ack;
    } ampi_link_t;

    typedef struct packed {
        logic [38:0] raw_s1;
        logic [38:0] raw_s2;
        logic [2:0]  ct_s;
        logic [2:0]  rd_s;
        logic [1:0]  ak_s;
        logic        pend;
        logic        pub_tgl;
        logic [31:0] pub;
        logic [7:0]  prim;
        logic [7:0]  sec;
        logic [15:0] tmr;
        logic        term;
        logic        perm;
        logic        ssr_mute;
        logic [3:0]  cur;
        logic [23:0] acc;
        logic [23:0] res;
        logic        unm_f;
        logic        unm_r;
    } ampi_core_t;

endpackage

// [tb/ampi_diag_checker.sv]
/* Port checker of the amplifier control and diagnostic byte bank.
   Assumes it is bound to ampi_diag_regs and sees its ports only. */
`timescale 1ns/1ns
module ampi_diag_checker (
    input wire logic       clk,                    // Core clock
    input wire logic       rst,                    // Reset
    input wire logic       link_clk,               // Bus side clock
    input wire logic       scl_in,                 // SCL level
    input wire logic       sda_in,                 // SDA level
    input wire logic       sda_oe,                 // SDA pull
    input wire logic [7:0] primary_control_byte,   // Primary byte
    input wire logic [7:0] secondary_control_byte, // Secondary byte
    input wire logic       unmute_front,           // Front playing
    input wire logic       unmute_rear             // Rear playing
);
    // ********
    // Bus and bytes
    // ********
    a_oe_scl_low: assert property (@(posedge link_clk) disable iff (rst)
        $changed(sda_oe) |-> !scl_in) else $error("sda pull moved with scl high");
    // Bytes commit on STOP, so the bus is idle whenever they move
    a_prim_commit: assert property (@(posedge clk) disable iff (rst)
        $changed(primary_control_byte) |-> scl_in && sda_in) else $error("primary moved mid frame");
    a_sec_commit: assert property (@(posedge clk) disable iff (rst)
        $changed(secondary_control_byte) |-> scl_in && sda_in) else $error("secondary moved mid frame");
    a_sec_zero_bits: assert property (@(posedge clk) disable iff (rst)
        (secondary_control_byte & 8'h42) == 8'h00) else $error("secondary reserved bit set");
    a_front_gate: assert property (@(posedge clk) disable iff (rst)
        unmute_front |-> $past(primary_control_byte[2])) else $error("front on while muted");
    a_rear_gate: assert property (@(posedge clk) disable iff (rst)
        unmute_rear |-> $past(primary_control_byte[1])) else $error("rear on while muted");
    a_front_on: assert property (@(posedge clk) disable iff (rst)
        (primary_control_byte[2] && !secondary_control_byte[0]) [*3] |=> unmute_front)
        else $error("front stays muted");
    a_rear_on: assert property (@(posedge clk) disable iff (rst)
        (primary_control_byte[1] && !secondary_control_byte[0]) [*3] |=> unmute_rear)
        else $error("rear stays muted");
endmodule

bind ampi_diag_regs ampi_diag_checker u_chk (.clk, .rst, .link_clk, .scl_in, .sda_in, .sda_oe,
    .primary_control_byte, .secondary_control_byte, .unmute_front, .unmute_rear);

// [tb/ampi_host_model.sv]
/* Bus master model: drives SCL, pulls SDA low.
   Assumes a pull-up on SDA; phases of 6 link clocks suit the target. */
`timescale 1ns/1ns
`include "ampi_params.svh"
module ampi_host_model (
    input  wire logic link_clk, // Bus side clock
    input  wire logic sda,      // Resolved SDA
    output logic      scl,      // SCL, idle high
    output logic      sda_pull  // High pulls SDA low
);
    initial begin
        scl = 1'b1;
        sda_pull = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge link_clk);
        #1;
    endtask

    task automatic start();
        tick(6);
        sda_pull = 1'b1;
        tick(6);
        scl = 1'b0;
    endtask

    task automatic stop();
        tick(3);
        sda_pull = 1'b1;
        tick(3);
        scl = 1'b1;
        tick(6);
        sda_pull = 1'b0;
        tick(6);
    endtask

    // Data moves only with SCL low; sampled late in the high phase
    task automatic bitx(input logic b, output logic r);
        tick(3);
        sda_pull = !b;
        tick(3);
        scl = 1'b1;
        tick(6);
        r = sda;
        scl = 1'b0;
    endtask

    task automatic xbyte(input logic [7:0] d, input logic ack_in, output logic [7:0] q, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            bitx(d[i], q[i]);
        end
        bitx(ack_in, ack);
    endtask

    // write bit, then exactly two bytes
    task automatic write(input logic [7:0] p, input logic [7:0] s, output logic [2:0] a);
        logic [7:0] q;
        start();
        xbyte({`AMPI_I2C_ADDR, 1'b0}, 1'b1, q, a[2]);
        xbyte(p, 1'b1, q, a[1]);
        xbyte(s & `AMPI_SEC_MASK, 1'b1, q, a[0]);
        stop();
    endtask

    // read bit, four bytes, NACK after the last
    task automatic read(output logic [31:0] d, output logic a);
        logic [7:0] q;
        logic       x;
        start();
        xbyte({`AMPI_I2C_ADDR, 1'b1}, 1'b1, q, a);
        for (int i = 0; i < 4; i++) begin
            xbyte(8'hFF, i == 3, q, x);
            d = {d[23:0], q};
        end
        stop();
    endtask
endmodule

// [tb/tb_amp_i2c_control_diag_regs.sv]
/* Self-checking bench of the amplifier control and diagnostic byte bank.
   Assumes the host model and checker are compiled before it. */
`timescale 1ns/1ns
`include "ampi_params.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin error_cnt++; \
    $display("CHECK FAILED %s exp %h got %h", nm, e, g); end end
module tb_amp_i2c_control_diag_regs;
    localparam int DIAG = 40;
    logic       clk = 1'b0;
    logic       link_clk = 1'b0;
    logic       rst = 1'b1;
    logic       clk_en = 1'b1;
    logic       scl, host_pull, sda_out, sda_oe, unmute_front, unmute_rear, diag_done;
    logic [3:0] short_load = 4'h0, out_offset = 4'h0, short_vcc = 4'h0, short_gnd = 4'h0;
    logic [3:0] cur_lt_250 = 4'h0, cur_gt_500 = 4'h0, cur_lt_125 = 4'h0, cur_gt_250 = 4'h0, open_load = 4'h0;
    logic [2:0] thermal_warn = 3'h0;
    logic [7:0] primary_control_byte, secondary_control_byte;
    int         error_cnt = 0, n_checks = 0, cyc = 0;
    wire        sda = !(sda_oe | host_pull);

    initial begin
        forever #4 clk = ~clk;
    end
    initial begin
        #3;
        forever #6 link_clk = ~link_clk;
    end

    ampi_host_model u_host (.link_clk, .sda, .scl, .sda_pull(host_pull));
    ampi_diag_regs #(.DIAG_CYCLES(DIAG)) u_dut (.clk, .rst, .clk_en, .link_clk, .scl_in(scl),
        .sda_in(sda), .sda_out, .sda_oe, .short_load, .open_load, .out_offset, .short_vcc,
        .short_gnd, .cur_lt_125, .cur_lt_250, .cur_gt_250, .cur_gt_500, .thermal_warn,
        .primary_control_byte, .secondary_control_byte, .unmute_front, .unmute_rear, .diag_done);

    // ********
    // Scenarios
    // ********
    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic t_reset();
        `CHK("rst_bytes", 16'h0000, {primary_control_byte, secondary_control_byte})
        `CHK("rst_outs", 5'h00, {sda_out, sda_oe, unmute_front, unmute_rear, diag_done})
        $display("test reset done");
    endtask

    // One bit at a time, so a swapped field shows
    task automatic t_ctrl_bits();
        logic [2:0] a;
        logic [7:0] v;
        for (int i = 0; i < 8; i++) begin
            v = 8'h01 << i;
            // the next write clears fast muting again
            u_host.write(v, v, a);
            wait_clk(8);
            `CHK("wr_ack", 3'h0, a)
            `CHK("primary", v, primary_control_byte)
            `CHK("secondary", v & `AMPI_SEC_MASK, secondary_control_byte)
            `CHK("unmute", {v[2], v[1]}, {unmute_front, unmute_rear})
        end
        $display("test control bits done");
    endtask

    task automatic t_refuse();
        logic [7:0] q;
        logic       a;
        u_host.start();
        u_host.xbyte({`AMPI_I2C_ADDR ^ 7'h01, 1'b0}, 1'b1, q, a);
        `CHK("bad_addr", 1'b1, a)
        u_host.stop();
        u_host.start();
        u_host.xbyte({`AMPI_I2C_ADDR, 1'b0}, 1'b1, q, a);
        u_host.xbyte(8'h55, 1'b1, q, a);
        u_host.stop();
        wait_clk(8);
        `CHK("kept", 16'h8080, {primary_control_byte, secondary_control_byte})
        $display("test refused writes done");
    endtask

    task automatic t_diag();
        logic [31:0] d;
        logic [2:0]  a;
        logic        k;
        u_host.write(8'h64, 8'h14, a);
        wait_clk(1);
        {short_gnd, short_vcc, short_load, out_offset} = 16'h1248;
        {thermal_warn, cur_lt_250, cur_gt_500} = 11'h54B;
        wait_clk(2 * DIAG);
        `CHK("done", 1'b1, diag_done)
        u_host.read(d, k);
        wait_clk(2 * DIAG);
        u_host.read(d, k);
        `CHK("rd_ack", 1'b0, k)
        `CHK("diag_bytes", 32'hD192_F854, d)
        `CHK("playing", 2'b10, {unmute_front, unmute_rear})
        wait_clk(1);
        short_gnd = 4'h0;
        u_host.read(d, k);
        `CHK("old_result", 8'hD1, d[31:24])
        wait_clk(2 * DIAG);
        u_host.read(d, k);
        `CHK("new_result", 8'hD0, d[31:24])
        $display("test diagnostics done");
    endtask

    task automatic t_safety();
        logic [31:0] d;
        logic [2:0]  a;
        logic        k;
        u_host.write(8'h66, 8'h11, a);
        wait_clk(2 * DIAG);
        `CHK("automute", 2'b00, {unmute_front, unmute_rear})
        u_host.read(d, k);
        wait_clk(2 * DIAG);
        u_host.read(d, k);
        `CHK("ssr_flags", 2'b11, d[23:22])
        $display("test safety routine done");
    endtask

    // Turn-on faults, low current threshold, and a frozen core
    task automatic t_turnon();
        logic [31:0] d;
        logic [2:0]  a;
        logic        k;
        wait_clk(1);
        {short_gnd, short_vcc, short_load, out_offset, open_load} = 20'h0_0043;
        {thermal_warn, cur_lt_250, cur_gt_500, cur_lt_125, cur_gt_250} = 19'h0_F087;
        clk_en = 1'b0;
        u_host.write(8'h40, 8'h84, a);
        wait_clk(8);
        `CHK("frozen", 8'h66, primary_control_byte)
        clk_en = 1'b1;
        wait_clk(8);
        `CHK("wr_ack2", 3'h0, a)
        `CHK("resumed", 16'h4084, {primary_control_byte, secondary_control_byte})
        u_host.read(d, k);
        wait_clk(2 * DIAG);
        u_host.read(d, k);
        `CHK("turnon_bytes", 32'h4404_4020, d)
        $display("test turn-on diagnostics done");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, error_cnt);
        if (error_cnt == 0 && n_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Whole run is near 14000 cycles; the ceiling leaves wide margin
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            final_report();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        #1;
        rst = 1'b0;
        t_reset();
        t_ctrl_bits();
        t_refuse();
        t_diag();
        t_safety();
        t_turnon();
        final_report();
    end
endmodule
